//--- verilog/asr_readout.sv
`timescale 1ns/1ns
`default_nettype none
module asr_readout
  import asr_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  input  wire logic                    scl_pin,
  input  wire logic                    sda_in,
  output var  logic                    sda_out,
  output var  logic                    sda_oe,
  input  wire logic                    addr_strap_pin,
  input  wire logic [2:0]              iface_select,
  input  wire logic                    fifo_enable,
  input  wire logic                    sample_valid,
  output var  logic                    sample_ready,
  input  wire logic [asr_pkg::SAMPLE_W-1:0] sample_x,
  input  wire logic [asr_pkg::SAMPLE_W-1:0] sample_y,
  input  wire logic [asr_pkg::SAMPLE_W-1:0] sample_z,
  input  wire logic                    clock_off,
  input  wire logic                    fuse_powered,
  input  wire logic                    watch_active,
  input  wire logic                    activity_event,
  input  wire logic [2:0]              mode_cmd,
  input  wire logic                    mode_cmd_valid,
  output var  logic [2:0]              mode_status,
  output var  logic                    continuous_wake,
  output var  logic                    fifo_advance,
  output var  logic                    output_frozen
);
  import asr_pkg::*;

  // Sign extension from a given resolution up to the full sample width.
  function automatic logic [SAMPLE_W-1:0] sext(input logic [SAMPLE_W-1:0] raw,
                                               input int res);
    logic [SAMPLE_W-1:0] val;
    val = raw;
    for (int i = 0; i < SAMPLE_W; i++) begin
      if (i >= res) begin
        val[i] = raw[res-1];
      end
    end
    return val;
  endfunction : sext

  logic                 scl_meta;
  logic                 scl_s;
  logic                 scl_q;
  logic                 sda_meta;
  logic                 sda_s;
  logic                 sda_q;
  logic                 strap_meta;
  logic                 strap_s;
  logic                 scl_rise;
  logic                 scl_fall;
  logic                 start_det;
  logic                 stop_det;
  asr_i2c_state_t       state_reg;
  logic [3:0]           bit_cnt_reg;
  logic [7:0]           shift_reg;
  logic [7:0]           tx_reg;
  logic [7:0]           ptr_reg;
  logic                 nack_reg;
  logic                 busy_reg;
  logic                 rd_load;
  logic [7:0]           rd_addr;
  logic [7:0]           rd_byte;
  logic [6:0]           my_addr;
  logic [1:0]           strap_wait_reg;
  logic                 strap_taken_reg;
  logic                 addr_select_bit;
  logic                 sample_overrun;
  logic                 watch_detect_reg;
  logic                 unread_reg;
  logic                 refill_reg;
  logic                 seq_ok_reg;
  logic [7:0]           last_rd_reg;
  logic                 seq_done;
  logic                 sample_read;
  logic                 cond_read;
  logic [SAMPLE_W-1:0]  x_accel;
  logic [SAMPLE_W-1:0]  y_accel;
  logic [SAMPLE_W-1:0]  z_accel;
  logic [7:0]           cond_status;
  logic                 buf_valid;
  logic                 buf_ready;
  logic [3*SAMPLE_W-1:0] buf_data;
  logic                 drain;

  // Two-flop synchronisers for the bus pins and the strap; the third stage finds edges.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      scl_meta   <= 1'b1;
      scl_s      <= 1'b1;
      scl_q      <= 1'b1;
      sda_meta   <= 1'b1;
      sda_s      <= 1'b1;
      sda_q      <= 1'b1;
      strap_meta <= 1'b0;
      strap_s    <= 1'b0;
    end else begin
      scl_meta   <= scl_pin;
      scl_s      <= scl_meta;
      scl_q      <= scl_s;
      sda_meta   <= sda_in;
      sda_s      <= sda_meta;
      sda_q      <= sda_s;
      strap_meta <= addr_strap_pin;
      strap_s    <= strap_meta;
    end
  end

  // Bus events seen on the synchronised lines.
  assign scl_rise  = scl_s && !scl_q;
  assign scl_fall  = !scl_s && scl_q;
  assign start_det = scl_s && scl_q && sda_q && !sda_s;
  assign stop_det  = scl_s && scl_q && !sda_q && sda_s;

  // The strap is caught once, after the synchronisers have settled past reset.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      strap_wait_reg  <= 2'h0;
      strap_taken_reg <= 1'b0;
      addr_select_bit <= 1'b0;
    end else if (!strap_taken_reg) begin
      if (strap_wait_reg == STRAP_SETTLE) begin
        addr_select_bit <= strap_s;
        strap_taken_reg <= 1'b1;
      end else begin
        strap_wait_reg <= strap_wait_reg + 2'h1;
      end
    end
  end

  assign my_addr = addr_select_bit ? BUS_ADDR_STRAP_HIGH : BUS_ADDR_STRAP_LOW;

  // Transaction window: frozen from START to STOP.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      busy_reg <= 1'b0;
    end else if (start_det) begin
      busy_reg <= 1'b1;
    end else if (stop_det) begin
      busy_reg <= 1'b0;
    end
  end

  assign output_frozen = busy_reg;

  // A byte is fetched for transmit after the address ack or a master ack.
  always_comb begin
    rd_load = 1'b0;
    rd_addr = ptr_reg;
    if (scl_fall && !start_det && !stop_det) begin
      if (state_reg == I2C_ACK_ADDR && shift_reg[1]) begin // R/W bit; the ack sits below it.
        rd_load = 1'b1;
      end else if (state_reg == I2C_MACK && !nack_reg) begin
        rd_load = 1'b1;
        rd_addr = ptr_reg + 8'h01;
      end
    end
  end

  // Read multiplexer; unmapped offsets read as zero.
  always_comb begin
    rd_byte = 8'h00;
    case (rd_addr)
      ADDR_STRAP_STATUS: rd_byte = {4'h0, addr_select_bit, 3'h0};
      DEV_COND_STATUS:   rd_byte = cond_status;
      X_ACCEL_LOW:       rd_byte = x_accel[7:0];
      X_ACCEL_HIGH:      rd_byte = x_accel[15:8];
      Y_ACCEL_LOW:       rd_byte = y_accel[7:0];
      Y_ACCEL_HIGH:      rd_byte = y_accel[15:8];
      Z_ACCEL_LOW:       rd_byte = z_accel[7:0];
      Z_ACCEL_HIGH:      rd_byte = z_accel[15:8];
      default:           rd_byte = 8'h00;
    endcase
  end

  // Two-wire slave: shift on SCL rise, change SDA on SCL fall.
  // Writes past the pointer byte are acknowledged and dropped; this map is read only.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg   <= I2C_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg   <= 8'h00;
      tx_reg      <= 8'h00;
      ptr_reg     <= 8'h00;
      nack_reg    <= 1'b1;
      sda_oe      <= 1'b0;
    end else if (start_det) begin
      state_reg   <= I2C_ADDR;
      bit_cnt_reg <= 4'h0;
      sda_oe      <= 1'b0;
    end else if (stop_det) begin
      state_reg <= I2C_IDLE;
      sda_oe    <= 1'b0;
    end else begin
      if (scl_rise) begin
        shift_reg   <= {shift_reg[6:0], sda_s};
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
        if (state_reg == I2C_MACK) begin
          nack_reg <= sda_s;
        end
      end
      if (rd_load) begin
        tx_reg      <= rd_byte;
        ptr_reg     <= rd_addr;
        sda_oe      <= !rd_byte[7];
        bit_cnt_reg <= 4'h0;
        state_reg   <= I2C_TX;
      end else if (scl_fall) begin
        case (state_reg)
          I2C_ADDR: begin
            if (bit_cnt_reg == BITS_PER_BYTE) begin
              if (shift_reg[7:1] == my_addr) begin
                sda_oe    <= 1'b1;
                state_reg <= I2C_ACK_ADDR;
              end else begin
                state_reg <= I2C_IDLE;
              end
            end
          end
          I2C_ACK_ADDR: begin
            sda_oe      <= 1'b0;
            bit_cnt_reg <= 4'h0;
            state_reg   <= I2C_PTR;
          end
          I2C_PTR: begin
            if (bit_cnt_reg == BITS_PER_BYTE) begin
              ptr_reg   <= shift_reg;
              sda_oe    <= 1'b1;
              state_reg <= I2C_ACK_WR;
            end
          end
          I2C_ACK_WR: begin
            sda_oe      <= 1'b0;
            bit_cnt_reg <= 4'h0;
            state_reg   <= I2C_WR;
          end
          I2C_WR: begin
            if (bit_cnt_reg == BITS_PER_BYTE) begin
              sda_oe    <= 1'b1;
              state_reg <= I2C_ACK_WR;
            end
          end
          I2C_TX: begin
            if (bit_cnt_reg == BITS_PER_BYTE) begin
              sda_oe    <= 1'b0;
              state_reg <= I2C_MACK;
            end else begin
              tx_reg <= {tx_reg[6:0], 1'b0};
              sda_oe <= !tx_reg[6];
            end
          end
          I2C_MACK: begin
            sda_oe    <= 1'b0;
            state_reg <= I2C_IDLE;
          end
          default: begin
            sda_oe    <= 1'b0;
            state_reg <= I2C_IDLE;
          end
        endcase
      end
    end
  end

  // Open drain: the data flop only ever pulls low.
  always_ff @(posedge clk) begin
    sda_out <= 1'b0;
  end

  // Track the 0x02..0x07 read walk; a break in the walk restarts it.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      seq_ok_reg  <= 1'b0;
      last_rd_reg <= 8'h00;
    end else if (rd_load) begin
      last_rd_reg <= rd_addr;
      if (rd_addr == X_ACCEL_LOW) begin
        seq_ok_reg <= 1'b1;
      end else if (rd_addr != last_rd_reg + 8'h01) begin
        seq_ok_reg <= 1'b0;
      end
    end
  end

  assign seq_done    = rd_load && seq_ok_reg && rd_addr == Z_ACCEL_HIGH
                       && last_rd_reg == Z_ACCEL_LOW;
  assign sample_read = rd_load && rd_addr == Z_ACCEL_HIGH;
  assign cond_read   = rd_load && rd_addr == DEV_COND_STATUS;

  // Buffer between the sample source and the output registers.
  asr_skid_buffer #(
    .WIDTH (3 * SAMPLE_W),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (sample_valid),
    .in_ready  (sample_ready),
    .in_data   ({sample_z, sample_y, sample_x}),
    .out_valid (buf_valid),
    .out_ready (buf_ready),
    .out_data  (buf_data)
  );

  // Loads stall while frozen, with no interface chosen, or while FIFO data awaits a full read.
  assign buf_ready = (iface_select != 3'h0) && !busy_reg
                     && (!fifo_enable || refill_reg);
  assign drain     = buf_valid && buf_ready;

  // Axis output registers, sign extended by source resolution.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      x_accel <= '0;
      y_accel <= '0;
      z_accel <= '0;
    end else if (drain) begin
      if (fifo_enable) begin
        x_accel <= sext(buf_data[SAMPLE_W-1:0], FIFO_RES);
        y_accel <= sext(buf_data[2*SAMPLE_W-1:SAMPLE_W], FIFO_RES);
        z_accel <= sext(buf_data[3*SAMPLE_W-1:2*SAMPLE_W], FIFO_RES);
      end else begin
        x_accel <= sext(buf_data[SAMPLE_W-1:0], DIRECT_RES);
        y_accel <= sext(buf_data[2*SAMPLE_W-1:SAMPLE_W], DIRECT_RES);
        z_accel <= sext(buf_data[3*SAMPLE_W-1:2*SAMPLE_W], DIRECT_RES);
      end
    end
  end

  // FIFO refill request and pointer advance after a complete walk.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      refill_reg   <= 1'b1;
      fifo_advance <= 1'b0;
    end else begin
      fifo_advance <= seq_done && fifo_enable;
      if (seq_done) begin
        refill_reg <= 1'b1;
      end else if (drain) begin
        refill_reg <= 1'b0;
      end
    end
  end

  // Unread tracking and overrun; a new overwrite in the read cycle wins over the clear.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      unread_reg     <= 1'b0;
      sample_overrun <= 1'b0;
    end else begin
      if (drain) begin
        unread_reg <= 1'b1;
      end else if (sample_read) begin
        unread_reg <= 1'b0;
      end
      if (drain && unread_reg) begin
        sample_overrun <= 1'b1;
      end else if (sample_read) begin
        sample_overrun <= 1'b0;
      end
    end
  end

  // Activity detect flag holds until the status byte is read; an event then wins.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      watch_detect_reg <= 1'b0;
    end else if (activity_event) begin
      watch_detect_reg <= 1'b1;
    end else if (cond_read) begin
      watch_detect_reg <= 1'b0;
    end
  end

  // Mode field: an activity event forces continuous wake over any command.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode_status     <= MODE_SLEEP;
      continuous_wake <= 1'b0;
    end else if (activity_event) begin
      mode_status     <= MODE_CONT_WAKE;
      continuous_wake <= 1'b1;
    end else if (mode_cmd_valid) begin
      mode_status     <= mode_cmd;
      continuous_wake <= (mode_cmd == MODE_CONT_WAKE);
    end
  end

  // Condition status byte; reserved bits hold their reset pattern.
  always_comb begin
    cond_status                   = DEV_COND_RESET;
    cond_status[OVERRUN_BIT]      = sample_overrun;
    cond_status[CLOCK_OFF_BIT]    = clock_off;
    cond_status[FUSE_POWER_BIT]   = fuse_powered;
    cond_status[WATCH_ACTIVE_BIT] = watch_active;
    cond_status[WATCH_DETECT_BIT] = watch_detect_reg;
  end

endmodule : asr_readout
`default_nettype wire

//--- verilog/asr_pkg.sv
package asr_pkg;

  // Register offsets inside the device map.
  localparam logic [7:0] ADDR_STRAP_STATUS  = 8'h00;
  localparam logic [7:0] DEV_COND_STATUS    = 8'h01;
  localparam logic [7:0] X_ACCEL_LOW        = 8'h02;
  localparam logic [7:0] X_ACCEL_HIGH       = 8'h03;
  localparam logic [7:0] Y_ACCEL_LOW        = 8'h04;
  localparam logic [7:0] Y_ACCEL_HIGH       = 8'h05;
  localparam logic [7:0] Z_ACCEL_LOW        = 8'h06;
  localparam logic [7:0] Z_ACCEL_HIGH       = 8'h07;

  // Reset values.
  localparam logic [7:0] ADDR_STRAP_RESET   = 8'h00;
  localparam logic [7:0] DEV_COND_RESET     = 8'h04;

  // Bit positions.
  localparam int ADDR_SELECT_BIT            = 3;
  localparam int OVERRUN_BIT                = 0;
  localparam int CLOCK_OFF_BIT              = 1;
  localparam int FUSE_POWER_BIT             = 5;
  localparam int WATCH_ACTIVE_BIT           = 6;
  localparam int WATCH_DETECT_BIT           = 7;

  // Two-wire slave base addresses chosen by the strap.
  localparam logic [6:0] BUS_ADDR_STRAP_LOW  = 7'h4C;
  localparam logic [6:0] BUS_ADDR_STRAP_HIGH = 7'h6C;

  // Mode field codes: sleep loaded by reset, and the code entered on activity detection.
  localparam logic [2:0] MODE_SLEEP         = 3'h0;
  localparam logic [2:0] MODE_CONT_WAKE     = 3'h5;

  // Sample widths: full, direct samples and FIFO samples; skid buffer depth.
  localparam int SAMPLE_W                   = 16;
  localparam int DIRECT_RES                 = 14;
  localparam int FIFO_RES                   = 12;
  localparam int BUF_DEPTH                  = 2;

  // Strap settle: cycles after reset release before the strap is caught; bits in one bus byte.
  localparam logic [1:0] STRAP_SETTLE       = 2'h3;
  localparam logic [3:0] BITS_PER_BYTE      = 4'h8;

  typedef enum logic [2:0] {
    I2C_IDLE, I2C_ADDR, I2C_ACK_ADDR, I2C_PTR, I2C_ACK_WR, I2C_WR, I2C_TX, I2C_MACK
  } asr_i2c_state_t;

endpackage : asr_pkg

//--- verilog/asr_skid_buffer.sv
`timescale 1ns/1ns
`default_nettype none
module asr_skid_buffer #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 2
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             in_valid,
  output var  logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output var  logic             out_valid,
  input  wire logic             out_ready,
  output var  logic [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr_reg;
  logic [PW-1:0]    rd_ptr_reg;
  logic [PW:0]      count_reg;
  logic [PW:0]      count_next;
  logic             push;
  logic             pop;

  // Ready is registered so the source sees a clean flop, at the cost of one cycle of lag after a pop.
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_valid = (count_reg != '0);
  assign out_data  = mem[rd_ptr_reg];

  // Occupancy after this cycle's push and pop.
  always_comb begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
  end

  // Pointers, occupancy and the registered ready.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
      in_ready   <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_next;
      in_ready  <= (count_next < (PW + 1)'(DEPTH));
    end
  end

  // Storage needs no reset; occupancy guards every read.
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

endmodule : asr_skid_buffer
`default_nettype wire

//--- verif/asr_readout_checker.sv
`timescale 1ns/1ns
`default_nettype none
module asr_readout_checker
  import asr_pkg::*;
(
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       scl_pin,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic [2:0] iface_select,
  input wire logic       sample_ready,
  input wire logic       fifo_enable,
  input wire logic       activity_event,
  input wire logic [2:0] mode_status,
  input wire logic       continuous_wake,
  input wire logic       fifo_advance,
  input wire logic       output_frozen
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // Bus conditions on the raw pins; the device lags them by its synchroniser.
  sequence start_seen;
    scl_pin && $fell(sda_in);
  endsequence
  sequence stop_seen;
    scl_pin && $rose(sda_in);
  endsequence

  a_start_freezes: assert property (start_seen |-> ##[1:6] output_frozen)
    else $error("outputs not frozen after a start");
  a_stop_thaws: assert property (stop_seen |-> ##[1:6] !output_frozen)
    else $error("outputs still frozen after a stop");
  a_event_wakes: assert property (activity_event |-> ##[1:2] mode_status == MODE_CONT_WAKE)
    else $error("activity event did not enter continuous wake");
  a_wake_mode_match: assert property ($stable(mode_status) [*2]
    |-> continuous_wake == (mode_status == MODE_CONT_WAKE))
    else $error("wake flag disagrees with mode field");
  a_none_stalls: assert property ((iface_select == 3'h0 && !sample_ready) [*2]
    |=> !sample_ready)
    else $error("samples drained with no interface selected");
  a_advance_fifo_only: assert property (fifo_advance |-> $past(fifo_enable))
    else $error("fifo advance outside fifo mode");
  a_advance_pulse: assert property (fifo_advance |=> !fifo_advance)
    else $error("fifo advance longer than one cycle");
  a_ack_scl_low: assert property ($changed(sda_oe) |-> !scl_pin)
    else $error("data line changed while clock high");
  a_pull_low_only: assert property (sda_oe |-> !sda_out && output_frozen)
    else $error("data line driven high or outside a frame");
endmodule : asr_readout_checker

bind asr_readout asr_readout_checker chk (
  .clk, .sys_rst, .scl_pin, .sda_in, .sda_out, .sda_oe, .iface_select,
  .sample_ready, .fifo_enable, .activity_event, .mode_status,
  .continuous_wake, .fifo_advance, .output_frozen
);
`default_nettype wire

//--- verif/asr_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module asr_host_model (
  input  wire logic clk,
  input  wire logic sda_line,
  output var  logic scl,
  output var  logic sda_low
);
  // Clock parked high and data released, so the bus is quiet between frames.
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // Start, repeated start and stop share one shape: set data to its first level, raise clock, move data.
  task automatic cond(input logic first, input logic last);
    scl <= 1'b0;
    repeat (2) @(posedge clk);
    sda_low <= first;
    repeat (3) @(posedge clk);
    scl <= 1'b1;
    repeat (4) @(posedge clk);
    sda_low <= last;
    repeat (4) @(posedge clk);
  endtask : cond

  // Nine bits, 80 ns each; the device answers in the low phase, so we sample late.
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      scl <= 1'b0;
      repeat (2) @(posedge clk);
      sda_low <= !tx[i];
      repeat (3) @(posedge clk);
      scl <= 1'b1;
      repeat (2) @(posedge clk);
      rx[i] = sda_line;
      @(posedge clk);
    end
  endtask : xfer

  // A burst read inside one start-to-stop frame keeps low and high bytes coherent.
  task automatic read_regs(input logic [6:0] dev, input logic [7:0] ptr, input int n,
                           output logic [7:0] d [9], output logic acked);
    logic [8:0] rx;
    cond(1'b0, 1'b1);
    xfer({dev, 1'b0, 1'b1}, rx);
    acked = !rx[0];
    if (acked) begin
      xfer({ptr, 1'b1}, rx);
      cond(1'b0, 1'b1);
      xfer({dev, 1'b1, 1'b1}, rx);
      for (int i = 0; i < n; i++) begin
        xfer({8'hFF, i == n - 1}, rx);
        d[i] = rx[8:1];
      end
    end
    cond(1'b1, 1'b0);
  endtask : read_regs
endmodule : asr_host_model
`default_nettype wire

//--- verif/asr_readout_test.sv
`timescale 1ns/1ns
`default_nettype none
module asr_readout_test;
  import asr_pkg::*;
  logic        clk = 1'b0, sys_rst = 1'b1, scl_pin, sda_in, sda_out, sda_oe, host_low;
  logic        addr_strap_pin = 1'b0, fifo_enable = 1'b0, sample_valid = 1'b0;
  logic [2:0]  iface_select = 3'h2, mode_cmd = 3'h0, mode_status;
  logic [15:0] sample_x = 16'h0000, sample_y = 16'h0000, sample_z = 16'h0000;
  logic        clock_off = 1'b0, fuse_powered = 1'b0, watch_active = 1'b0;
  logic        activity_event = 1'b0, mode_cmd_valid = 1'b0, sample_ready;
  logic        continuous_wake, fifo_advance, output_frozen, rd_ack;
  logic [7:0]  rd_d [9];
  int          bad_count = 0, checks_done = 0, cycles = 0, adv_count = 0;

  // Open-drain data line with a pull-up: low if either party pulls it.
  assign sda_in = !(host_low || (sda_oe && !sda_out));

  asr_readout dut (.clk, .sys_rst, .scl_pin, .sda_in, .sda_out, .sda_oe, .addr_strap_pin,
    .iface_select, .fifo_enable, .sample_valid, .sample_ready, .sample_x, .sample_y,
    .sample_z, .clock_off, .fuse_powered, .watch_active, .activity_event, .mode_cmd,
    .mode_cmd_valid, .mode_status, .continuous_wake, .fifo_advance, .output_frozen);
  asr_host_model host (.clk, .sda_line(sda_in), .scl(scl_pin), .sda_low(host_low));

  // Clock, fifo advance tally and a hang limit well above the expected run length.
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (fifo_advance === 1'b1)
      adv_count <= adv_count + 1;
    if (cycles == 60000) begin
      bad_count++;
      summarize();
    end
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize

  function automatic logic [15:0] sx(input logic [15:0] v, input int res);
    return (res == FIFO_RES) ? {{4{v[11]}}, v[11:0]} : {{2{v[13]}}, v[13:0]};
  endfunction : sx

  task automatic rd(input logic [7:0] ptr, input int n);
    host.read_regs(BUS_ADDR_STRAP_LOW, ptr, n, rd_d, rd_ack);
    check("ack", rd_ack, 1'b1);
  endtask : rd

  task automatic cmp_axis(input logic [15:0] x, y, z, input int res);
    check("x_accel", {rd_d[1], rd_d[0]}, sx(x, res));
    check("y_accel", {rd_d[3], rd_d[2]}, sx(y, res));
    check("z_accel", {rd_d[5], rd_d[4]}, sx(z, res));
  endtask : cmp_axis

  task automatic chk_axis(input logic [15:0] x, y, z, input int res);
    rd(X_ACCEL_LOW, 6);
    cmp_axis(x, y, z, res);
  endtask : chk_axis

  // The word is held until the edge that samples ready high, so none is lost.
  task automatic push(input logic [15:0] x, y, z);
    int n;
    sample_x <= x;
    sample_y <= y;
    sample_z <= z;
    sample_valid <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (sample_ready !== 1'b1 && n < 100);
    sample_valid <= 1'b0;
    check("taken", sample_ready, 1'b1);
    @(posedge clk);
  endtask : push

  task automatic test_reset();
    rd(ADDR_STRAP_STATUS, 9);
    check("strap", rd_d[0], ADDR_STRAP_RESET);
    check("cond", rd_d[1], DEV_COND_RESET);
    for (int i = 2; i < 9; i++)
      check("zero", rd_d[i], 8'h00);
    host.read_regs(BUS_ADDR_STRAP_HIGH, ADDR_STRAP_STATUS, 1, rd_d, rd_ack);
    check("nack", rd_ack, 1'b0);
    $display("test_reset done");
  endtask : test_reset

  task automatic test_status();
    clock_off <= 1'b1;
    fuse_powered <= 1'b1;
    watch_active <= 1'b1;
    rd(DEV_COND_STATUS, 1);
    check("live", rd_d[0], 8'h66);
    activity_event <= 1'b1;
    @(posedge clk);
    activity_event <= 1'b0;
    repeat (3) @(posedge clk);
    check("mode", mode_status, MODE_CONT_WAKE);
    check("wake", continuous_wake, 1'b1);
    rd(DEV_COND_STATUS, 1);
    check("detect", rd_d[0], 8'hE6);
    clock_off <= 1'b0;
    fuse_powered <= 1'b0;
    watch_active <= 1'b0;
    mode_cmd_valid <= 1'b1;
    @(posedge clk);
    mode_cmd_valid <= 1'b0;
    rd(DEV_COND_STATUS, 1);
    check("idle", rd_d[0], 8'h04);
    check("sleep", mode_status, MODE_SLEEP);
    $display("test_status done");
  endtask : test_status

  task automatic test_iface();
    iface_select <= 3'h0;
    push(16'h2001, 16'h1FFF, 16'h3ABC);
    push(16'hD234, 16'h2345, 16'h0F0F);
    repeat (4) @(posedge clk);
    check("full", sample_ready, 1'b0);
    chk_axis(16'h0000, 16'h0000, 16'h0000, DIRECT_RES);
    iface_select <= 3'h1;
    repeat (10) @(posedge clk);
    rd(DEV_COND_STATUS, 1);
    check("overrun", rd_d[0], 8'h05);
    chk_axis(16'hD234, 16'h2345, 16'h0F0F, DIRECT_RES);
    rd(DEV_COND_STATUS, 1);
    check("cleared", rd_d[0], 8'h04);
    $display("test_iface done");
  endtask : test_iface

  task automatic test_freeze();
    iface_select <= 3'h4;
    fork
      rd(X_ACCEL_LOW, 6);
      begin
        for (int n = 0; n < 300 && output_frozen !== 1'b1; n++)
          @(posedge clk);
        check("frozen", output_frozen, 1'b1);
        push(16'h0123, 16'h3456, 16'h0789);
      end
    join
    cmp_axis(16'hD234, 16'h2345, 16'h0F0F, DIRECT_RES);
    repeat (10) @(posedge clk);
    chk_axis(16'h0123, 16'h3456, 16'h0789, DIRECT_RES);
    $display("test_freeze done");
  endtask : test_freeze

  task automatic test_fifo();
    int base;
    base = adv_count;
    fifo_enable <= 1'b1;
    push(16'h0800, 16'h07FF, 16'h3C00);
    rd(X_ACCEL_LOW, 6);
    repeat (10) @(posedge clk);
    check("advance", 16'(adv_count - base), 16'h0001);
    chk_axis(16'h0800, 16'h07FF, 16'h3C00, FIFO_RES);
    rd(X_ACCEL_LOW, 3);
    repeat (10) @(posedge clk);
    check("partial", 16'(adv_count - base), 16'h0002);
    fifo_enable <= 1'b0;
    $display("test_fifo done");
  endtask : test_fifo

  task automatic test_strap();
    addr_strap_pin <= 1'b1;
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (12) @(posedge clk);
    host.read_regs(BUS_ADDR_STRAP_HIGH, ADDR_STRAP_STATUS, 1, rd_d, rd_ack);
    check("ack_high", rd_ack, 1'b1);
    check("strap", rd_d[0], 8'h08);
    host.read_regs(BUS_ADDR_STRAP_LOW, ADDR_STRAP_STATUS, 1, rd_d, rd_ack);
    check("nack_low", rd_ack, 1'b0);
    $display("test_strap done");
  endtask : test_strap

  // Reset for two cycles, let the strap settle, then run every scenario once.
  initial begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (12) @(posedge clk);
    test_reset();
    test_status();
    test_iface();
    test_freeze();
    test_fifo();
    test_strap();
    summarize();
  end
endmodule : asr_readout_test
`default_nettype wire
